/* hw/art_consts.vh */
// Register map, field positions and codes of the auto-reload timer
`ifndef ART_CONSTS_VH
`define ART_CONSTS_VH

// Register indices; byte address is four times the index
`define ART_IDX_MODE_CTRL      8'hd5
`define ART_IDX_FLAGS          8'hd6
`define ART_IDX_CLK_EDGE_PS    8'hd7
`define ART_IDX_RELOAD_CAPTURE 8'hd9
`define ART_IDX_COMPARE        8'hda
`define ART_IDX_COUNTER_LIVE   8'hdb

// Reset values
`define ART_RST_MODE_CTRL      8'h00
`define ART_RST_FLAGS          3'h0
`define ART_RST_CLK_EDGE_PS    8'h00
`define ART_RST_RELOAD         8'h00
`define ART_RST_COMPARE        8'h00

// Mode control fields
`define ART_MC_LOAD_NOW        7
`define ART_MC_COUNT_EN        6
`define ART_MC_PULSE_OE        5
`define ART_MC_EDGE_MASK       4
`define ART_MC_CMP_MASK        3
`define ART_MC_OVF_MASK        2
`define ART_MC_MODE_HI         1
`define ART_MC_MODE_LO         0

// Flag fields
`define ART_FL_EDGE            2
`define ART_FL_CMP             1
`define ART_FL_OVF             0

// Clock, edge and prescale fields
`define ART_CE_PS_HI           7
`define ART_CE_PS_LO           5
`define ART_CE_RESERVED        4
`define ART_CE_EDGE_FALL       3
`define ART_CE_EDGE_EN         2
`define ART_CE_CLK_HI          1
`define ART_CE_CLK_LO          0

// Operating modes
`define ART_MODE_AUTO_RELOAD   2'h0
`define ART_MODE_CAPTURE       2'h1
`define ART_MODE_CAPTURE_RST   2'h2
`define ART_MODE_EDGE_LOAD     2'h3

// Clock sources
`define ART_CLK_INTERNAL       2'h0
`define ART_CLK_DIV3           2'h1
`define ART_CLK_PIN            2'h2

// Misc counts
`define ART_DIV3_LAST          2'h2
`define ART_COUNT_MAX          8'hff
`define ART_HTRANS_NONSEQ_BIT  1

`endif

/* hw/art_pin_sync.v */
// Three-stage synchroniser with agreement filter and edge pulses for the timer input pin
module art_pin_sync (
    // Clock and reset
    input  wire sys_clk_i,
    input  wire reset_i,
    // Asynchronous pin
    input  wire pin_i,
    // Filtered level and one-cycle edge pulses
    output reg  level_o,
    output reg  rise_o,
    output reg  fall_o
);

    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;

    // Stage chain; level changes only once stages two and three agree
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            level_o   <= 1'b0;
            rise_o    <= 1'b0;
            fall_o    <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            rise_o    <= 1'b0;
            fall_o    <= 1'b0;
            if (sync2_reg == sync3_reg && sync3_reg != level_o) begin
                level_o <= sync3_reg;
                rise_o  <= sync3_reg;
                fall_o  <= ~sync3_reg;
            end
        end
    end

endmodule // art_pin_sync

/* hw/art_timer.v */
// Auto-reload timer with PWM output, capture and AHB-Lite register slave
// Function
// - Reset clears mode control to zero
// - Load bit reloads counter, clears prescaler, reads zero
// - Count enable clear freezes counting; capture-reset and edge-load edges still load counter and prescaler
// - Pulse pin driven only with output enable
// - Edge request when edge flag and mask
// - Compare request when compare flag and mask
// - Overflow request when overflow flag and mask
// - Mode bits select reload, capture, capture-reset, edge-load
// - Flags readable; writing one leaves them unchanged
// - Active input edge sets edge flag; zero clears
// - Counter equal compare sets compare flag
// - Rollover from max to the reload value sets overflow flag
// - Prescale ratio two to code; no disturbance
// - Edge detect enable and polarity select
// - Clock source internal, divided by three, pin
// - Live counter access; reset leaves it unchanged
// - Reload value copied into counter on overflow
// - Live register write loads counter immediately
// - Capture modes copy counter on active edge
// - Pulse pin high on overflow, low on compare
// - Edge-load mode copies reload value on edge
//
// The AHB-Lite slave port was left to the implementer.
`include "art_consts.vh"

module art_timer #(
    parameter PS_WIDTH = 7
) (
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        reset_i,
    // AHB-Lite slave
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg         hreadyout_o,
    output reg         hresp_o,
    output reg  [31:0] hrdata_o,
    // Timer pins
    input  wire        timer_input_pin_i,
    output reg         pulse_output_pin_o,
    // Interrupt request to the core
    output reg         timer_irq_o
);

    // Reset image of mode control; bit seven is never stored
    localparam [7:0] MODE_CTRL_RST = `ART_RST_MODE_CTRL;

    // Mask of prescaler bits that must all be one for a tick
    // Code zero gives an empty mask, so every source tick counts
    function [PS_WIDTH-1:0] ps_mask;
        input [2:0] code;
        integer i;
        begin
            ps_mask = {PS_WIDTH{1'b0}};
            for (i = 0; i < PS_WIDTH; i = i + 1) begin
                if (i < code) begin
                    ps_mask[i] = 1'b1;
                end
            end
        end
    endfunction

    // Register index match
    function idx_hit;
        input [7:0] idx;
        input [7:0] addr_idx;
        begin
            idx_hit = (addr_idx == idx);
        end
    endfunction

    // Software visible state
    reg  [6:0]          mode_ctrl_reg;
    reg  [2:0]          flags_reg;
    reg  [2:0]          flags_next;
    reg  [7:0]          clk_edge_ps_reg;
    reg  [7:0]          reload_capture_reg;
    reg  [7:0]          reload_capture_next;
    reg  [7:0]          compare_value_reg;
    // Counting state
    reg  [7:0]          main_count_reg;
    reg  [7:0]          main_count_next;
    reg  [PS_WIDTH-1:0] prescaler_count_reg;
    reg  [PS_WIDTH-1:0] prescaler_count_next;
    reg  [1:0]          div3_reg;
    reg                 pwm_level_reg;
    reg                 pwm_level_next;
    // Bus data phase state
    reg                 wr_pending_reg;
    reg  [7:0]          wr_idx_reg;

    wire                pin_level;
    wire                pin_rise;
    wire                pin_fall;

    // Decoded fields
    wire       count_enable        = mode_ctrl_reg[`ART_MC_COUNT_EN];
    wire       pulse_output_enable = mode_ctrl_reg[`ART_MC_PULSE_OE];
    wire [1:0] mode_select         = {mode_ctrl_reg[`ART_MC_MODE_HI],
                                      mode_ctrl_reg[`ART_MC_MODE_LO]};
    wire [2:0] prescale_select     = clk_edge_ps_reg[`ART_CE_PS_HI:`ART_CE_PS_LO];
    wire       edge_detect_en      = clk_edge_ps_reg[`ART_CE_EDGE_EN];
    wire       edge_falling        = clk_edge_ps_reg[`ART_CE_EDGE_FALL];
    wire [1:0] clock_source_select = clk_edge_ps_reg[`ART_CE_CLK_HI:`ART_CE_CLK_LO];
    wire [2:0] irq_masks           = {mode_ctrl_reg[`ART_MC_EDGE_MASK],
                                      mode_ctrl_reg[`ART_MC_CMP_MASK],
                                      mode_ctrl_reg[`ART_MC_OVF_MASK]};

    // Bus address phase and data phase decode
    wire       addr_phase = hsel_i & htrans_i[`ART_HTRANS_NONSEQ_BIT] & hready_i;
    wire [7:0] addr_idx   = haddr_i[9:2];
    wire       map_hit    = (haddr_i[31:10] == 22'h000000);

    wire wr_mode    = wr_pending_reg & idx_hit(`ART_IDX_MODE_CTRL, wr_idx_reg);
    wire wr_flags   = wr_pending_reg & idx_hit(`ART_IDX_FLAGS, wr_idx_reg);
    wire wr_clk     = wr_pending_reg & idx_hit(`ART_IDX_CLK_EDGE_PS, wr_idx_reg);
    wire wr_reload  = wr_pending_reg & idx_hit(`ART_IDX_RELOAD_CAPTURE, wr_idx_reg);
    wire wr_compare = wr_pending_reg & idx_hit(`ART_IDX_COMPARE, wr_idx_reg);
    wire wr_live    = wr_pending_reg & idx_hit(`ART_IDX_COUNTER_LIVE, wr_idx_reg);
    wire [7:0] wdata = hwdata_i[7:0];

    wire load_now = wr_mode & wdata[`ART_MC_LOAD_NOW];

    // Rollover test and plain increment of the live count
    wire       count_at_max   = (main_count_reg == `ART_COUNT_MAX);
    wire [7:0] count_plus_one = main_count_reg + 8'h01;

    // Input pin synchroniser
    // Three stages and the filter flop, so edges act four to five cycles late
    art_pin_sync u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .pin_i     (timer_input_pin_i),
        .level_o   (pin_level),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // Selected active edge; disabled when detect enable is clear
    wire active_edge = edge_detect_en & (edge_falling ? pin_fall : pin_rise);

    // Source tick before prescaling
    reg src_tick;
    always @* begin
        case (clock_source_select)
            `ART_CLK_INTERNAL: src_tick = 1'b1;
            `ART_CLK_DIV3:     src_tick = (div3_reg == `ART_DIV3_LAST);
            `ART_CLK_PIN:      src_tick = pin_rise;
            default:           src_tick = 1'b0;
        endcase
    end

    // Selected prescaler mask, shared by the tick test
    wire [PS_WIDTH-1:0] ps_sel_mask = ps_mask(prescale_select);

    // Prescaled counter tick, only while counting
    wire ps_tick = count_enable & src_tick &
                   ((prescaler_count_reg & ps_sel_mask)
                    == ps_sel_mask);

    // Counter, prescaler, capture and pulse level
    always @* begin
        // Defaults hold every value
        main_count_next      = main_count_reg;
        prescaler_count_next = prescaler_count_reg;
        reload_capture_next  = reload_capture_reg;
        pwm_level_next       = pwm_level_reg;
        flags_next           = flags_reg;

        // Software clears by zero; ones leave the flag alone
        // Hardware sets come later, so a set beats a clear
        if (wr_flags) begin
            flags_next = flags_reg & wdata[2:0];
        end
        if (wr_reload) begin
            reload_capture_next = wdata;
        end

        // Prescaler advances on source ticks while enabled
        if (count_enable & src_tick) begin
            prescaler_count_next = prescaler_count_reg + {{(PS_WIDTH-1){1'b0}}, 1'b1};
        end

        // Counting on the prescaled tick
        // Compare sees the updated count and wins over overflow
        if (ps_tick) begin
            if (count_at_max) begin
                main_count_next                = reload_capture_reg;
                prescaler_count_next           = {PS_WIDTH{1'b0}};
                flags_next[`ART_FL_OVF]        = 1'b1;
                pwm_level_next                 = 1'b1;
            end else begin
                main_count_next = count_plus_one;
            end
            if (main_count_next == compare_value_reg) begin
                flags_next[`ART_FL_CMP] = 1'b1;
                pwm_level_next          = 1'b0;
            end
        end

        // Active input edge actions depend on mode
        // Capture takes the count from before this cycle
        if (active_edge) begin
            flags_next[`ART_FL_EDGE] = 1'b1;
            case (mode_select)
                `ART_MODE_AUTO_RELOAD: begin
                    main_count_next = main_count_next;
                end
                `ART_MODE_CAPTURE: begin
                    reload_capture_next = main_count_reg;
                end
                `ART_MODE_CAPTURE_RST: begin
                    reload_capture_next  = main_count_reg;
                    main_count_next      = 8'h00;
                    prescaler_count_next = {PS_WIDTH{1'b0}};
                end
                `ART_MODE_EDGE_LOAD: begin
                    main_count_next      = reload_capture_reg;
                    prescaler_count_next = {PS_WIDTH{1'b0}};
                end
                default: begin
                    main_count_next = main_count_next;
                end
            endcase
        end

        // Priority: live write, then load bit, then edge, then tick
        // Load bit copies reload value and clears prescaler
        if (load_now) begin
            main_count_next      = reload_capture_reg;
            prescaler_count_next = {PS_WIDTH{1'b0}};
        end

        // Live register write loads the counter at once
        if (wr_live) begin
            main_count_next      = wdata;
            prescaler_count_next = {PS_WIDTH{1'b0}};
        end
    end

    // Control registers under reset
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            mode_ctrl_reg      <= MODE_CTRL_RST[6:0];
            flags_reg          <= `ART_RST_FLAGS;
            clk_edge_ps_reg    <= `ART_RST_CLK_EDGE_PS;
            reload_capture_reg <= `ART_RST_RELOAD;
            compare_value_reg  <= `ART_RST_COMPARE;
            pwm_level_reg      <= 1'b0;
            div3_reg           <= 2'h0;
        end else begin
            if (wr_mode) begin
                mode_ctrl_reg <= wdata[6:0];
            end
            if (wr_clk) begin
                clk_edge_ps_reg <= wdata;
            end
            if (wr_compare) begin
                compare_value_reg <= wdata;
            end
            flags_reg          <= flags_next;
            reload_capture_reg <= reload_capture_next;
            pwm_level_reg      <= pwm_level_next;
            // Divide-by-three stepper, frozen while stopped
            // Frozen too, so a stopped timer loses no source phase
            if (count_enable) begin
                if (div3_reg == `ART_DIV3_LAST) begin
                    div3_reg <= 2'h0;
                end else begin
                    div3_reg <= div3_reg + 2'h1;
                end
            end
        end
    end

    // Counter and prescaler keep their contents through reset
    // Software must load them before enabling the count
    always @(posedge sys_clk_i) begin
        main_count_reg      <= main_count_next;
        prescaler_count_reg <= prescaler_count_next;
    end

    // Pin and interrupt outputs from flops
    // Request is a level one edge behind the flags
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            pulse_output_pin_o <= 1'b0;
            timer_irq_o        <= 1'b0;
        end else begin
            pulse_output_pin_o <= pulse_output_enable & pwm_level_reg;
            timer_irq_o        <= |(flags_reg & irq_masks);
        end
    end

    // Read data for the address being taken
    // Unmapped places and high addresses read as zero
    reg [7:0] rd_value;
    always @* begin
        rd_value = 8'h00;
        if (map_hit) begin
            case (addr_idx)
                `ART_IDX_MODE_CTRL:      rd_value = {1'b0, mode_ctrl_reg};
                `ART_IDX_FLAGS:          rd_value = {5'h00, flags_reg};
                `ART_IDX_CLK_EDGE_PS:    rd_value = clk_edge_ps_reg;
                `ART_IDX_RELOAD_CAPTURE: rd_value = reload_capture_reg;
                `ART_IDX_COMPARE:        rd_value = compare_value_reg;
                `ART_IDX_COUNTER_LIVE:   rd_value = main_count_reg;
                default:                 rd_value = 8'h00;
            endcase
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    // Write data is taken one edge after its address
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            hreadyout_o    <= 1'b1;
            hresp_o        <= 1'b0;
            hrdata_o       <= 32'h00000000;
            wr_pending_reg <= 1'b0;
            wr_idx_reg     <= 8'h00;
        end else begin
            hreadyout_o    <= 1'b1;
            hresp_o        <= 1'b0;
            wr_pending_reg <= addr_phase & hwrite_i & map_hit;
            if (addr_phase) begin
                wr_idx_reg <= addr_idx;
                if (!hwrite_i) begin
                    hrdata_o <= {24'h000000, rd_value};
                end
            end
        end
    end

    // Filtered pin level and hsize_i folded into one net that nothing reads
    wire unused_level = pin_level & (^hsize_i);

endmodule // art_timer

/* tb/art_pin_model.sv */
// Far-side model driving the timer input pin; its pulse pin input is left unread
module art_pin_model (
    // Clock
    input  wire  sys_clk_i,
    // Pins
    output logic pin_o,
    input  wire  pulse_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_o = 1'b0;
    // One full pulse, prompt or slow by width
    task automatic strobe(input int width);
        repeat (width) @(posedge sys_clk_i);
        pin_o <= 1'b1;
        repeat (width) @(posedge sys_clk_i);
        pin_o <= 1'b0;
    endtask
    // Single level change for polarity checks
    task automatic level(input logic lvl);
        @(posedge sys_clk_i);
        pin_o <= lvl;
    endtask
endmodule // art_pin_model

/* tb/art_timer_chk.sv */
// Concurrent checks on the ports of the auto-reload timer
`include "art_consts.vh"
module art_timer_chk #(
    parameter PS_WIDTH = 7
) (
    // Clock and reset
    input wire        sys_clk_i,
    input wire        reset_i,
    // AHB-Lite slave
    input wire        hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [2:0]  hsize_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire        hreadyout_o,
    input wire        hresp_o,
    input wire [31:0] hrdata_o,
    // Timer pins and request
    input wire        timer_input_pin_i,
    input wire        pulse_output_pin_o,
    input wire        timer_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address phase decode
    wire       take_w = hsel_i & htrans_i[1] & hready_i;
    wire [7:0] idx_w  = haddr_i[9:2];
    wire       rd_w   = take_w & ~hwrite_i;
    reg        mc_wr_reg;
    reg  [6:0] mc_reg;
    // Mirror of mode control built from completed writes
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            mc_wr_reg <= 1'b0;
            mc_reg    <= 7'h00;
        end else if (hready_i) begin
            mc_wr_reg <= take_w & hwrite_i & (idx_w == `ART_IDX_MODE_CTRL);
            if (mc_wr_reg)
                mc_reg <= hwdata_i[6:0];
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    chk_always_okay: assert property (hreadyout_o && !hresp_o)
        else $error("slave not ready or not okay");
    chk_reset_quiet: assert property ($past(reset_i) |->
        (!timer_irq_o && !pulse_output_pin_o && hrdata_o == 32'h0))
        else $error("outputs not quiet after reset");
    chk_ctrl_readback: assert property (rd_w && idx_w == `ART_IDX_MODE_CTRL |=>
        hrdata_o == {25'h0, $past(mc_reg)})
        else $error("mode control read wrong");
    chk_upper_zero: assert property (hrdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_unmapped_zero: assert property (rd_w && !(idx_w inside {`ART_IDX_MODE_CTRL,
        `ART_IDX_FLAGS, `ART_IDX_CLK_EDGE_PS, `ART_IDX_RELOAD_CAPTURE, `ART_IDX_COMPARE,
        `ART_IDX_COUNTER_LIVE}) |=> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!rd_w |=> $stable(hrdata_o))
        else $error("read data changed without read");
    chk_pulse_off: assert property (!mc_reg[5] |=> !pulse_output_pin_o)
        else $error("pulse pin active while disabled");
    chk_irq_masked: assert property (mc_reg[4:2] == 3'h0 |=> !timer_irq_o)
        else $error("request with all masks off");
    cov_pulse_rise: cover property ($rose(pulse_output_pin_o));
    cov_irq_rise: cover property ($rose(timer_irq_o));
    cov_ctrl_read: cover property (rd_w && idx_w == `ART_IDX_MODE_CTRL);
endmodule // art_timer_chk

bind art_timer art_timer_chk #(.PS_WIDTH(PS_WIDTH)) art_timer_chk_i (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .timer_input_pin_i(timer_input_pin_i),
    .pulse_output_pin_o(pulse_output_pin_o), .timer_irq_o(timer_irq_o));

/* tb/testbench.sv */
// Self-checking testbench of the auto-reload timer
`include "art_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [7:0] MC = `ART_IDX_MODE_CTRL;
    localparam [7:0] FL = `ART_IDX_FLAGS;
    localparam [7:0] CE = `ART_IDX_CLK_EDGE_PS;
    localparam [7:0] RC = `ART_IDX_RELOAD_CAPTURE;
    localparam [7:0] LV = `ART_IDX_COUNTER_LIVE;
    // Bus master and pin signals
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        hsel_i    = 1'b0;
    logic [31:0] haddr_i   = 32'h0;
    logic [1:0]  htrans_i  = 2'h0;
    logic        hwrite_i  = 1'b0;
    logic [2:0]  hsize_i   = 3'h0;
    logic [31:0] hwdata_i  = 32'h0;
    wire         hreadyout_o;
    wire         hresp_o;
    wire  [31:0] hrdata_o;
    wire         pin_w;
    wire         pulse_w;
    wire         irq_w;
    int          fail_count = 0;
    int          cmp_count  = 0;
    logic [31:0] v;
    logic [7:0]  ml [4] = '{8'h40, 8'h40, 8'h00, 8'h77};
    logic [7:0]  mr [4] = '{8'h77, 8'h40, 8'h40, 8'h77};
    always #12.5 sys_clk_i = ~sys_clk_i;
    art_timer art_timer_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hrdata_o(hrdata_o), .timer_input_pin_i(pin_w),
        .pulse_output_pin_o(pulse_w), .timer_irq_o(irq_w));
    art_pin_model art_pin_model_i (.sys_clk_i(sys_clk_i), .pin_o(pin_w), .pulse_i(pulse_w));
    // Verdict and end of run
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle: address phase, then data phase, each held until hready
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk_i);
        hsel_i   <= 1'b1;
        haddr_i  <= {22'h0, idx, 2'h0};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        hsize_i  <= 3'h2;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        v = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx);
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic do_reset(input int n);
        reset_i <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        reset_i <= 1'b0;
    endtask
    // Reset values and an unmapped place
    task automatic t_reset();
        logic [7:0] regs [6] = '{MC, FL, CE, RC, `ART_IDX_COMPARE, 8'hd8};
        foreach (regs[i]) begin
            rd(regs[i]);
            check(v, 32'h0);
        end
    endtask
    // Live counter access, freeze, survival across reset, load bit
    task automatic t_live();
        wr(LV, 8'h5a);
        rd(LV);
        check(v, 32'h5a);
        repeat (20) @(posedge sys_clk_i);
        rd(LV);
        check(v, 32'h5a);
        do_reset(3);
        rd(LV);
        check(v, 32'h5a);
        wr(RC, 8'h33);
        wr(MC, 8'h80);
        rd(MC);
        check(v, 32'h0);
        rd(LV);
        check(v, 32'h33);
    endtask
    // Counts over a fixed span for a given clock register setting
    task automatic run(input logic [7:0] ce, input int cyc, input int pulses, input int e);
        wr(LV, 8'h00);
        wr(CE, ce);
        wr(MC, 8'h40);
        repeat (pulses) art_pin_model_i.strobe(6);
        repeat (cyc) @(posedge sys_clk_i);
        wr(MC, 8'h00);
        rd(LV);
        check({31'h0, v + 32'h1 >= e && v <= e + 1}, 32'h1);
    endtask
    task automatic t_clocks();
        for (int c = 0; c < 8; c++)
            run({c[2:0], 5'h00}, 8 << c, 0, 8 + (3 >> c));
        run(8'h01, 30, 0, 11);
        run(8'h02, 8, 5, 5);
        run(8'h03, 30, 0, 0);
        wr(CE, 8'h00);
    endtask
    task automatic wait_pulse(input logic lvl);
        for (int n = 0; n < 40 && pulse_w !== lvl; n++)
            @(posedge sys_clk_i);
        check(pulse_w, lvl);
    endtask
    // Overflow with reload, compare, flag clearing and masks
    task automatic t_ovf();
        wr(LV, 8'hfd);
        wr(RC, 8'h10);
        wr(`ART_IDX_COMPARE, 8'h18);
        wr(MC, 8'h64);
        wait_pulse(1'b1);
        repeat (2) @(posedge sys_clk_i);
        check(irq_w, 1'b1);
        wait_pulse(1'b0);
        wr(MC, 8'h24);
        rd(LV);
        check({31'h0, v >= 32'h18 && v <= 32'h28}, 32'h1);
        rd(FL);
        check(v, 32'h03);
        wr(FL, 8'h07);
        rd(FL);
        check(v, 32'h03);
        wr(FL, 8'h02);
        rd(FL);
        check(v, 32'h02);
        check(irq_w, 1'b0);
        wr(MC, 8'h08);
        rd(FL);
        check(irq_w, 1'b1);
        wr(FL, 8'h00);
        rd(FL);
        check(v, 32'h0);
        check(irq_w, 1'b0);
        // Overflow raises the level while the pin is disabled
        wr(LV, 8'hfe);
        wr(MC, 8'h44);
        repeat (4) @(posedge sys_clk_i);
        check(pulse_w, 1'b0);
        wr(MC, 8'h20);
        repeat (2) @(posedge sys_clk_i);
        check(pulse_w, 1'b1);
        wr(MC, 8'h00);
    endtask
    // Every mode on one slow rising edge
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(LV, 8'h40);
            wr(RC, 8'h77);
            wr(FL, 8'h00);
            wr(CE, 8'h04);
            wr(MC, 8'h10 | m[7:0]);
            art_pin_model_i.strobe(12);
            repeat (8) @(posedge sys_clk_i);
            rd(LV);
            check(v, {24'h0, ml[m]});
            rd(RC);
            check(v, {24'h0, mr[m]});
            rd(FL);
            check(v, 32'h04);
            check(irq_w, 1'b1);
        end
        wr(MC, 8'h00);
    endtask
    // Edge detect off, then falling polarity
    task automatic t_edges();
        wr(CE, 8'h08);
        wr(FL, 8'h00);
        art_pin_model_i.strobe(6);
        repeat (8) @(posedge sys_clk_i);
        rd(FL);
        check(v, 32'h0);
        wr(CE, 8'h0c);
        art_pin_model_i.level(1'b1);
        repeat (8) @(posedge sys_clk_i);
        rd(FL);
        check(v, 32'h0);
        art_pin_model_i.level(1'b0);
        repeat (8) @(posedge sys_clk_i);
        rd(FL);
        check(v, 32'h04);
    endtask
    initial begin
        #(25ns * 20000);
        fail_count++;
        summarize();
    end
    initial begin
        do_reset(12);
        t_reset();
        t_live();
        t_clocks();
        t_ovf();
        t_modes();
        t_edges();
        summarize();
    end
endmodule // testbench
